// ===== inc/swrl_pkg.sv
package swrl_pkg;

  // timing
  localparam int CLK_HZ        = 25_000_000;
  localparam int HOLDOFF_NS    = 100;
  localparam int HOLDOFF_CYC   = (HOLDOFF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int OSC_HZ        = 30_000;
  localparam int OSC_CYC       = CLK_HZ / OSC_HZ;
  localparam int DIV_DELAY_MS  = 2;
  localparam int DIV_DELAY_CYC = DIV_DELAY_MS * (CLK_HZ / 1000);

  // ROM command codes
  localparam logic [7:0] CMD_SEARCH = 8'hF0;
  localparam logic [7:0] CMD_READ   = 8'h33;
  localparam logic [7:0] CMD_MATCH  = 8'h55;
  localparam logic [7:0] CMD_SKIP   = 8'hCC;
  localparam logic [7:0] CMD_RESUME = 8'hA5;
  localparam logic [7:0] CMD_OD_SKP = 8'h3C;
  localparam logic [7:0] CMD_OD_MAT = 8'h69;

  // divisor sequences, first byte in the low bits
  localparam logic [63:0] SEQ_A      = 64'h0000_C3F9_753D_01DD;
  localparam logic [31:0] SEQ_A_RESP = 32'hFFFF_C5CE;
  localparam logic [15:0] SEQ_B      = 16'h85AA;
  localparam logic [7:0]  CODE_OSC_HALVED  = 8'h41;
  localparam logic [7:0]  CODE_OSC_QUARTERED  = 8'h42;
  localparam logic [7:0]  CODE_OSC_EIGHTH  = 8'h43;
  localparam logic [7:0]  ARG_OSC_HALVED   = 8'h02;
  localparam logic [6:0]  BIT_PAT    = 7'b0000010;
  localparam logic [15:0] RESP_OSC_HALVED  = 16'h5F7E;
  localparam logic [15:0] RESP_OSC_QUARTERED  = 16'hAF7E;
  localparam logic [15:0] RESP_OSC_EIGHTH  = 16'h3F7F;

  // register map
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_STATUS = 8'h04;
  localparam logic [7:0]  REG_FUNC   = 8'h08;
  localparam logic [7:0]  REG_SLOTS  = 8'h0C;
  localparam logic [7:0]  REG_ID_LO  = 8'h10;
  localparam logic [7:0]  REG_ID_HI  = 8'h14;
  localparam int          CTRL_EN    = 0;
  localparam int          CTRL_RCCLR = 1;
  localparam logic        EN_RST     = 1'b1;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_DEC   = 2'h3;

  typedef enum logic [1:0] {SWRL_OSC_UNDIVIDED, SWRL_OSC_HALVED, SWRL_OSC_QUARTERED, SWRL_OSC_EIGHTH} swrl_div_t;

  typedef struct packed {
    logic rst_pulse;
    logic valid;
    logic level;
  } swrl_slot_t;

  typedef struct packed {
    logic [21:0] rsvd;
    logic        line_high;
    logic        armed;
    swrl_div_t   div;
    logic        resume;
    logic [4:0]  state;
  } swrl_status_t;

  function automatic logic [7:0] swrl_crc8(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
    end
    return c;
  endfunction : swrl_crc8

endpackage : swrl_pkg

// ===== design/swrl_front.sv
`timescale 1ns/1ps
module swrl_front
  import swrl_pkg::*;
(
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // line comparators
  input  wire logic below_low,
  input  wire logic above_high,
  // filtered line
  output logic      line_high,
  output logic      slot_start
);

  typedef enum {FE_LOW, FE_HOLD, FE_HIGH} swrl_fe_t;

  swrl_fe_t   fe_reg;
  logic [3:0] hold_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fe_reg     <= FE_LOW;
      hold_reg   <= 4'h0;
      line_high  <= 1'b0;
      slot_start <= 1'b0;
    end else begin
      slot_start <= 1'b0;
      unique case (fe_reg)
        FE_LOW: begin
          if (above_high && !below_low) begin
            fe_reg   <= FE_HOLD;
            hold_reg <= 4'h0;
          end
        end
        FE_HOLD: begin
          if (below_low) begin
            fe_reg <= FE_LOW;
          end else if (hold_reg == 4'(HOLDOFF_CYC - 1)) begin
            fe_reg    <= FE_HIGH;
            line_high <= 1'b1;
          end else begin
            hold_reg <= hold_reg + 4'h1;
          end
        end
        FE_HIGH: begin
          // only a true low restarts timing; upper dips are noise
          if (below_low) begin
            fe_reg     <= FE_LOW;
            line_high  <= 1'b0;
            slot_start <= 1'b1;
          end
        end
      endcase
    end
  end

  default clocking fcb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  hold_restart_a: assert property ((fe_reg == FE_HOLD && below_low) |=> fe_reg == FE_LOW && !line_high) else $error("dip during hold-off not filtered");
  hold_len_a: assert property ($rose(line_high) |-> $past(fe_reg, 3) == FE_HOLD) else $error("hold-off too short");
  slot_edge_a: assert property ((fe_reg == FE_HIGH && below_low) |=> slot_start) else $error("slot start missed");
  hyst_keep_a: assert property ((fe_reg == FE_HIGH && !below_low) |=> line_high && !slot_start) else $error("glitch not filtered");

endmodule : swrl_front

// ===== design/swrl_top.sv
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
// Behaviour
// - search: send true ID bit, then complement, then read controller's chosen bit
// - drop out of search when the written bit differs from own ID bit
// - read ROM sends family code, 48-bit serial, then CRC, LSB first
// - match ROM compares 64 bits; function phase only on exact match
// - skip ROM goes straight to function command reception
// - resume with flag set acts like skip ROM
// - resume flag set only by successful match, search or overdrive match
// - resume flag cleared when another device gets selected
// - once high, disturbances not reaching the lower threshold are ignored
// - 100ns hold-off after rising edge; a dip restarts it
// - a fall after hold-off starts a new slot
// - oscillator undivided after reset; volatile divide by 2, 4 or 8
// - divisor scales the slow oscillator tick, never slot handling
// - first phase DD 01 3D 75 F9 C3 answered with CE C5 FF FF
// - divide by 2: AA 85 41 02 answered with 7E 5F
// - divide by 4: AA 85 42, bits 0100000, 2ms, bit 0, answer 7E AF
// - divide by 8: AA 85 43, bits 0100000, 2ms, bit 0, answer 7F 3F
// - ROM commands are 8-bit codes; 69h selects by identifier like match
module swrl_top
  import swrl_pkg::*;
#(
  parameter int          DIV_DELAY = DIV_DELAY_CYC,
  parameter logic [7:0]  FAMILY    = 8'h5A,             // arbitrary value
  parameter logic [47:0] SERIAL    = 48'h0123_4567_89AB // arbitrary value
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // line comparators
  input  wire logic        below_low,
  input  wire logic        above_high,
  // slot layer
  input  wire swrl_slot_t  slot,
  output logic             line_pull_low,
  // oscillator divisor
  output logic             osc_undivided,
  output logic             osc_halved,
  output logic             osc_quartered,
  output logic             osc_eighth,
  output logic             osc_tick,
  // register bus
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  localparam logic [63:0] ROM_ID = {swrl_crc8({SERIAL, FAMILY}), SERIAL, FAMILY};

  typedef enum {ST_WAIT, ST_CMD, ST_SEARCH, ST_READ, ST_MATCH,
                ST_FUNC, ST_TX, ST_PAT, ST_DLY} swrl_st_t;

  swrl_st_t     st_reg;
  swrl_div_t    div_reg;
  swrl_div_t    pdiv_reg;
  logic [6:0]   bitc_reg;
  logic [1:0]   ph_reg;
  logic [7:0]   sh_reg;
  logic         mism_reg;
  logic         rc_reg;
  logic         arm_reg;
  logic [2:0]   fidx_reg;
  logic         fmode_reg;
  logic [31:0]  tx_reg;
  logic [5:0]   txn_reg;
  logic [15:0]  dly_reg;
  logic [7:0]   func_reg;
  logic         pend_reg;
  logic         en_reg;
  logic         rcclr_reg;
  logic [31:0]  slots_reg;
  logic [9:0]   pre_reg;
  logic [2:0]   post_reg;
  logic [7:0]   awaddr_reg;
  logic [31:0]  wdata_reg;
  logic [3:0]   wstrb_reg;
  logic         aw_hold;
  logic         w_hold;
  logic         line_high;
  logic         slot_start;
  logic         slot_ok;
  logic [7:0]   sh_next;
  logic         id_bit;
  logic         cur_bit;
  logic         tx_active;
  logic         dly_done;
  logic [31:0]  rd_data;
  swrl_status_t status;

  swrl_front u_front (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .below_low  (below_low),
    .above_high (above_high),
    .line_high  (line_high),
    .slot_start (slot_start)
  );

  function automatic logic [15:0] div_resp(input swrl_div_t d);
    unique case (d)
      SWRL_OSC_HALVED: return RESP_OSC_HALVED;
      SWRL_OSC_QUARTERED: return RESP_OSC_QUARTERED;
      SWRL_OSC_EIGHTH: return RESP_OSC_EIGHTH;
      default:   return 16'h0000;
    endcase
  endfunction : div_resp

  function automatic logic mapped(input logic [7:0] a);
    return a == REG_CTRL || a == REG_STATUS || a == REG_FUNC ||
           a == REG_SLOTS || a == REG_ID_LO || a == REG_ID_HI;
  endfunction : mapped

  // a slot counts only if the filtered front end saw its falling edge
  assign slot_ok  = slot.valid && pend_reg && en_reg;
  assign sh_next  = {slot.level, sh_reg[7:1]};
  assign id_bit   = ROM_ID[bitc_reg[5:0]];
  assign dly_done = dly_reg == 16'(DIV_DELAY);

  always_comb begin
    cur_bit   = 1'b1;
    tx_active = 1'b0;
    unique case (st_reg)
      ST_SEARCH: begin
        cur_bit   = (ph_reg == 2'h0) ? id_bit : !id_bit;
        tx_active = ph_reg != 2'h2;
      end
      ST_READ: begin
        cur_bit   = id_bit;
        tx_active = 1'b1;
      end
      ST_TX: begin
        cur_bit   = tx_reg[0];
        tx_active = 1'b1;
      end
      default: ;
    endcase
  end

  // pull low one cycle after the previous slot; slots are far longer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_pull_low <= 1'b0;
    end else begin
      line_pull_low <= en_reg && tx_active && !cur_bit;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_reg  <= 1'b0;
      slots_reg <= 32'h0000_0000;
    end else begin
      pend_reg <= slot_start || (pend_reg && !slot_ok && !slot.rst_pulse);
      if (slot_start) begin
        slots_reg <= slots_reg + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg    <= ST_WAIT;
      bitc_reg  <= 7'h00;
      ph_reg    <= 2'h0;
      sh_reg    <= 8'h00;
      mism_reg  <= 1'b0;
      rc_reg    <= 1'b0;
      arm_reg   <= 1'b0;
      fidx_reg  <= 3'h0;
      fmode_reg <= 1'b0;
      pdiv_reg  <= SWRL_OSC_UNDIVIDED;
      div_reg   <= SWRL_OSC_UNDIVIDED;
      tx_reg    <= 32'h0000_0000;
      txn_reg   <= 6'h00;
      dly_reg   <= 16'h0000;
      func_reg  <= 8'h00;
    end else begin
      // software clear first so a same-cycle hardware set wins
      if (rcclr_reg) begin
        rc_reg <= 1'b0;
      end
      if (st_reg == ST_DLY && !dly_done) begin
        dly_reg <= dly_reg + 16'h0001;
      end
      if (slot.rst_pulse) begin
        st_reg   <= ST_CMD;
        bitc_reg <= 7'h00;
        ph_reg   <= 2'h0;
        mism_reg <= 1'b0;
        fidx_reg <= 3'h0;
      end else if (slot_ok) begin
        sh_reg <= sh_next;
        unique case (st_reg)
          ST_WAIT: ;
          ST_CMD: begin
            bitc_reg <= bitc_reg + 7'h01;
            if (bitc_reg == 7'h07) begin
              bitc_reg <= 7'h00;
              case (sh_next)
                CMD_SEARCH:            st_reg <= ST_SEARCH;
                CMD_READ:              st_reg <= ST_READ;
                CMD_MATCH, CMD_OD_MAT: st_reg <= ST_MATCH;
                CMD_SKIP, CMD_OD_SKP:  st_reg <= ST_FUNC;
                CMD_RESUME:            st_reg <= rc_reg ? ST_FUNC : ST_WAIT;
                default:               st_reg <= ST_WAIT;
              endcase
            end
          end
          ST_SEARCH: begin
            ph_reg <= ph_reg + 2'h1;
            if (ph_reg == 2'h2) begin
              ph_reg <= 2'h0;
              if (slot.level != id_bit) begin
                st_reg <= ST_WAIT;
                rc_reg <= 1'b0;
              end else if (bitc_reg == 7'h3F) begin
                st_reg   <= ST_FUNC;
                bitc_reg <= 7'h00;
                rc_reg   <= 1'b1;
              end else begin
                bitc_reg <= bitc_reg + 7'h01;
              end
            end
          end
          ST_READ: begin
            bitc_reg <= bitc_reg + 7'h01;
            if (bitc_reg == 7'h3F) begin
              st_reg   <= ST_FUNC;
              bitc_reg <= 7'h00;
            end
          end
          ST_MATCH: begin
            bitc_reg <= bitc_reg + 7'h01;
            mism_reg <= mism_reg || (slot.level != id_bit);
            if (bitc_reg == 7'h3F) begin
              bitc_reg <= 7'h00;
              if (!mism_reg && slot.level == id_bit) begin
                st_reg <= ST_FUNC;
                rc_reg <= 1'b1;
              end else begin
                st_reg <= ST_WAIT;
                rc_reg <= 1'b0;
              end
            end
          end
          ST_FUNC: begin
            bitc_reg <= bitc_reg + 7'h01;
            if (bitc_reg[2:0] == 3'h7) begin
              bitc_reg <= 7'h00;
              fidx_reg <= fidx_reg + 3'h1;
              if (fidx_reg == 3'h0) begin
                if (sh_next == SEQ_A[7:0]) begin
                  fmode_reg <= 1'b0;
                end else if (sh_next == SEQ_B[7:0] && arm_reg) begin
                  fmode_reg <= 1'b1;
                end else begin
                  func_reg <= sh_next;
                  st_reg   <= ST_WAIT;
                end
              end else if (!fmode_reg) begin
                if (sh_next != SEQ_A[{fidx_reg, 3'h0} +: 8]) begin
                  st_reg  <= ST_WAIT;
                  arm_reg <= 1'b0;
                end else if (fidx_reg == 3'h5) begin
                  tx_reg  <= SEQ_A_RESP;
                  txn_reg <= 6'd32;
                  arm_reg <= 1'b1;
                  st_reg  <= ST_TX;
                end
              end else if (fidx_reg == 3'h1) begin
                if (sh_next != SEQ_B[15:8]) begin
                  st_reg <= ST_WAIT;
                end
              end else if (fidx_reg == 3'h2) begin
                case (sh_next)
                  CODE_OSC_HALVED: pdiv_reg <= SWRL_OSC_HALVED;
                  CODE_OSC_QUARTERED: begin
                    pdiv_reg <= SWRL_OSC_QUARTERED;
                    st_reg   <= ST_PAT;
                  end
                  CODE_OSC_EIGHTH: begin
                    pdiv_reg <= SWRL_OSC_EIGHTH;
                    st_reg   <= ST_PAT;
                  end
                  default:   st_reg <= ST_WAIT;
                endcase
              end else if (sh_next == ARG_OSC_HALVED) begin
                div_reg <= pdiv_reg;
                tx_reg  <= {16'h0000, div_resp(pdiv_reg)};
                txn_reg <= 6'd16;
                arm_reg <= 1'b0;
                st_reg  <= ST_TX;
              end else begin
                st_reg <= ST_WAIT;
              end
            end
          end
          ST_PAT: begin
            bitc_reg <= bitc_reg + 7'h01;
            if (slot.level != BIT_PAT[bitc_reg[2:0]]) begin
              st_reg <= ST_WAIT;
            end else if (bitc_reg == 7'h06) begin
              st_reg  <= ST_DLY;
              dly_reg <= 16'h0000;
            end
          end
          ST_DLY: begin
            // a bit before the delay ends aborts the setting
            if (dly_done && !slot.level) begin
              div_reg <= pdiv_reg;
              tx_reg  <= {16'h0000, div_resp(pdiv_reg)};
              txn_reg <= 6'd16;
              arm_reg <= 1'b0;
              st_reg  <= ST_TX;
            end else begin
              st_reg <= ST_WAIT;
            end
          end
          ST_TX: begin
            tx_reg  <= tx_reg >> 1;
            txn_reg <= txn_reg - 6'h01;
            if (txn_reg == 6'h01) begin
              st_reg <= ST_WAIT;
            end
          end
        endcase
      end
    end
  end

  // slow tick: slot handling never looks at it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_reg       <= 10'h000;
      post_reg      <= 3'h0;
      osc_tick      <= 1'b0;
      osc_undivided <= 1'b1;
      osc_halved    <= 1'b0;
      osc_quartered <= 1'b0;
      osc_eighth    <= 1'b0;
    end else begin
      osc_undivided <= div_reg == SWRL_OSC_UNDIVIDED;
      osc_halved    <= div_reg == SWRL_OSC_HALVED;
      osc_quartered <= div_reg == SWRL_OSC_QUARTERED;
      osc_eighth    <= div_reg == SWRL_OSC_EIGHTH;
      osc_tick      <= 1'b0;
      pre_reg       <= pre_reg + 10'h001;
      if (pre_reg == 10'(OSC_CYC - 1)) begin
        pre_reg  <= 10'h000;
        post_reg <= post_reg + 3'h1;
        if (post_reg >= (3'h7 >> (2'h3 - div_reg))) begin
          post_reg <= 3'h0;
          osc_tick <= 1'b1;
        end
      end
    end
  end

  assign status = '{rsvd: 22'h0, line_high: line_high, armed: arm_reg,
                    div: div_reg, resume: rc_reg, state: 5'(st_reg)};

  always_comb begin
    unique case (s_axi_araddr)
      REG_CTRL:   rd_data = {31'h0, en_reg};
      REG_STATUS: rd_data = status;
      REG_FUNC:   rd_data = {24'h0, func_reg};
      REG_SLOTS:  rd_data = slots_reg;
      REG_ID_LO:  rd_data = ROM_ID[31:0];
      REG_ID_HI:  rd_data = ROM_ID[63:32];
      default:    rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
      en_reg        <= EN_RST;
      rcclr_reg     <= 1'b0;
    end else begin
      rcclr_reg <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_reg    <= s_axi_awaddr;
        aw_hold       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
        w_hold       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_hold && w_hold) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awaddr_reg) ? RESP_OKAY : RESP_DEC;
        if (awaddr_reg == REG_CTRL && wstrb_reg[0]) begin
          en_reg    <= wdata_reg[CTRL_EN];
          rcclr_reg <= wdata_reg[CTRL_RCCLR];
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_data;
        s_axi_rresp   <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_DEC;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  search_drop_a: assert property ((st_reg == ST_SEARCH && ph_reg == 2'h2 && slot_ok && !slot.rst_pulse && slot.level != id_bit) |=> st_reg == ST_WAIT && !rc_reg) else $error("search not left on mismatch");
  search_bits_a: assert property ((st_reg == ST_SEARCH && ph_reg == 2'h1 && en_reg) |=> line_pull_low == $past(id_bit)) else $error("complement bit wrong");
  read_end_a: assert property ((st_reg == ST_READ && slot_ok && !slot.rst_pulse && bitc_reg == 7'h3F) |=> st_reg == ST_FUNC) else $error("read ROM end wrong");
  match_fail_a: assert property ((st_reg == ST_MATCH && slot_ok && !slot.rst_pulse && bitc_reg == 7'h3F && mism_reg) |=> st_reg == ST_WAIT && !rc_reg) else $error("mismatched match accepted");
  skip_func_a: assert property ((st_reg == ST_CMD && slot_ok && !slot.rst_pulse && bitc_reg == 7'h07 && sh_next == CMD_SKIP) |=> st_reg == ST_FUNC && bitc_reg == 7'h00) else $error("skip ROM not direct");
  resume_go_a: assert property ((st_reg == ST_CMD && slot_ok && !slot.rst_pulse && bitc_reg == 7'h07 && sh_next == CMD_RESUME) |=> st_reg == ($past(rc_reg) ? ST_FUNC : ST_WAIT)) else $error("resume decision wrong");
  wait_hold_a: assert property ((st_reg == ST_WAIT && !slot.rst_pulse) |=> st_reg == ST_WAIT) else $error("left idle without reset");
  rc_source_a: assert property ($rose(rc_reg) |-> $past(st_reg) == ST_SEARCH || $past(st_reg) == ST_MATCH) else $error("resume flag set wrongly");
  div_default_a: assert property ($rose(aresetn) |-> osc_undivided && div_reg == SWRL_OSC_UNDIVIDED) else $error("divisor not reset");
  seq_a_resp_a: assert property ((st_reg == ST_FUNC && !fmode_reg && fidx_reg == 3'h5 && bitc_reg == 7'h07 && slot_ok && !slot.rst_pulse && sh_next == SEQ_A[47:40]) |=> st_reg == ST_TX && tx_reg == SEQ_A_RESP && txn_reg == 6'd32) else $error("first phase answer wrong");
  dly_early_a: assert property ((st_reg == ST_DLY && slot_ok && !slot.rst_pulse && !dly_done) |=> st_reg == ST_WAIT && $stable(div_reg)) else $error("early bit accepted");

endmodule : swrl_top

// ===== tb/swrl_ctl_model.sv
`timescale 1ns/1ps
module swrl_ctl_model
  import swrl_pkg::*;
(
  input  wire logic  aclk,
  input  wire logic  pull,
  output logic       below_low,
  output logic       above_high,
  output swrl_slot_t slot
);
  initial begin
    below_low = 0;
    above_high = 1;
    slot = '0;
  end
  task automatic rp();
    @(posedge aclk) slot.rst_pulse <= 1;
    @(posedge aclk) slot.rst_pulse <= 0;
  endtask : rp
  // rise past hold-off, then fall; read slot is wired-and with device pull
  task automatic bit_io(input logic b, output logic r);
    @(posedge aclk) above_high <= 1;
    below_low <= 0;
    @(posedge aclk) below_low <= 1;
    above_high <= 0;
    @(posedge aclk) below_low <= 0;
    above_high <= 1;
    repeat (4) @(posedge aclk);
    above_high <= 0;
    @(posedge aclk) r = b & ~pull;
    below_low <= 1;
    // valid only once the filtered fall has armed the slot
    repeat (2) @(posedge aclk);
    slot.valid <= 1;
    slot.level <= r;
    @(posedge aclk) slot.valid <= 0;
  endtask : bit_io
  task automatic io8(input logic [7:0] v, output logic [7:0] r);
    for (int i = 0; i < 8; i++) bit_io(v[i], r[i]);
  endtask : io8
endmodule : swrl_ctl_model

// ===== tb/swrl_top_tb.sv
`timescale 1ns/1ps
module swrl_top_tb
  import swrl_pkg::*;
;
  localparam logic [55:0] ID56 = 56'h0123_4567_89AB_5A;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [7:0] awa = 0, ara = 0, b;
  logic [31:0] wd = 0, d;
  logic [1:0] rs;
  logic bl, ah, pl, ou, oh, oq, oe, awr, wr_r, bv, arr, rv, tk;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [63:0] id, q;
  swrl_slot_t slot;
  int errors = 0, samples_checked = 0;
  initial forever #20 aclk = ~aclk;
  swrl_ctl_model u (.aclk(aclk), .pull(pl), .below_low(bl), .above_high(ah), .slot(slot));
  swrl_top #(.DIV_DELAY(20), .FAMILY(8'h5A), .SERIAL(48'h0123_4567_89AB)) DUT (
    .aclk(aclk), .aresetn(aresetn), .below_low(bl), .above_high(ah), .slot(slot),
    .line_pull_low(pl), .osc_undivided(ou), .osc_halved(oh), .osc_quartered(oq),
    .osc_eighth(oe), .osc_tick(tk), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));
  function automatic logic [7:0] crc(input logic [55:0] x);
    logic [7:0] c = 8'h00;
    for (int i = 0; i < 56; i++) c = (c[0] ^ x[i]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
    return c;
  endfunction : crc
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  task automatic wt(ref logic s);
    int n = 0;
    do @(posedge aclk); while (s !== 1'b1 && ++n < 99);
    if (n >= 99) begin
      errors++;
      report_and_stop();
    end
  endtask : wt
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk) {awv, wv, br} <= 3'h7;
    awa <= a;
    wd <= v;
    wt(awr);
    {awv, wv} <= 2'h0;
    wt(bv);
    rs = bresp;
    br <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk) {arv, rr} <= 2'h3;
    ara <= a;
    wt(arr);
    arv <= 0;
    wt(rv);
    d = rdata;
    rs = rresp;
    rr <= 0;
  endtask : rd
  task automatic rx(input int n);
    for (int j = 0; j < n; j++) u.io8(8'hFF, q[j*8+:8]);
  endtask : rx
  task automatic gap(input int e);
    int t = 0, k = 0, n = 0;
    while (k < 2) begin
      @(posedge aclk);
      n += k;
      if (tk === 1'b1) k++;
      if (++t > 4 * e) begin
        errors++;
        report_and_stop();
      end
    end
    chk(n == e, "tick spacing");
  endtask : gap
  task automatic t_reset();
    chk({ou, oh, oq, oe} === 4'h8, "divisor after reset");
    wr(8'h40, 0);
    chk(rs === RESP_DEC, "unmapped write");
    wr(REG_CTRL, 32'h3);
    chk(rs === RESP_OKAY, "ctrl write");
    rd(8'h40);
    chk(rs === RESP_DEC, "unmapped read");
    gap(OSC_CYC);
    $display("reset test done");
  endtask : t_reset
  task automatic t_rom();
    u.rp();
    u.io8(CMD_READ, b);
    rx(8);
    chk(q === id, "read rom id");
    $display("read rom test done");
  endtask : t_rom
  task automatic t_search();
    logic x, y;
    u.rp();
    u.io8(CMD_SEARCH, b);
    for (int j = 0; j < 64; j++) begin
      u.bit_io(1'b1, x);
      u.bit_io(1'b1, y);
      chk({x, y} === {id[j], ~id[j]}, "search bit pair");
      u.bit_io(id[j], x);
    end
    rd(REG_STATUS);
    chk(d[5:0] === 6'h25, "search selects");
    u.rp();
    u.io8(CMD_SEARCH, b);
    u.io8(8'hFF, b);
    rd(REG_STATUS);
    chk(d[5:0] === 6'h00, "search dropout");
    $display("search test done");
  endtask : t_search
  task automatic sel(input logic [7:0] c, input logic [63:0] v, input logic [5:0] e);
    u.rp();
    u.io8(c, b);
    if (c == CMD_MATCH) for (int j = 0; j < 8; j++) u.io8(v[j*8+:8], b);
    rd(REG_STATUS);
    chk(d[5:0] === e, "status after select");
  endtask : sel
  task automatic t_res();
    sel(CMD_RESUME, 0, 6'h00);
    sel(CMD_MATCH, id, 6'h25);
    sel(CMD_RESUME, 0, 6'h25);
    sel(CMD_MATCH, id ^ 1, 6'h00);
    $display("resume test done");
  endtask : t_res
  task automatic ph1();
    u.rp();
    u.io8(CMD_SKIP, b);
    for (int j = 0; j < 6; j++) u.io8(SEQ_A[j*8+:8], b);
    rx(4);
    chk(q[31:0] === 32'hFFFF_C5CE, "first phase answer");
    u.rp();
    u.io8(CMD_SKIP, b);
    u.io8(8'hAA, b);
    u.io8(8'h85, b);
  endtask : ph1
  task automatic t_div();
    ph1();
    u.io8(8'h41, b);
    u.io8(8'h02, b);
    rx(2);
    chk({ou, oh} === 2'h1, "halved divisor");
    chk(q[15:0] === 16'h5F7E, "second phase answer");
    gap(2 * OSC_CYC);
    $display("divisor test done");
  endtask : t_div
  task automatic t_osc_quartered();
    logic x;
    ph1();
    u.io8(8'h42, b);
    for (int j = 0; j < 7; j++) u.bit_io(j == 1, x);
    repeat (20) @(posedge aclk);
    u.bit_io(1'b0, x);
    rx(2);
    chk(q[15:0] === 16'hAF7E, "quarter answer");
    chk({ou, oh, oq} === 3'h1, "quartered divisor");
    $display("quarter test done");
  endtask : t_osc_quartered
  initial begin
    id = {crc(ID56), ID56};
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    t_reset();
    t_rom();
    t_search();
    t_res();
    t_div();
    t_osc_quartered();
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    t_reset();
    t_div();
    report_and_stop();
  end
endmodule : swrl_top_tb
